// ==== bench/iid_monitor.sv ====
// Port checker for the interrupt detect block.
// Bound from the bench top file; sees top-level ports only.
`timescale 1ns/1ns
module iid_monitor (
  // Clock, reset and APB
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Requests and results
  input wire logic i_console_halt,
  input wire logic i_port_fast_interrupt,
  input wire logic [4:0] i_skip_control_field,
  input wire logic o_skip_taken,
  input wire logic o_processor_interrupt_flag
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  reset_flag_clear_a: assert property ($rose(i_rst_b) |-> !o_processor_interrupt_flag)
    else $error("flag set just after reset");
  setup_ready_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  error_ready_a: assert property (o_pslverr |-> o_pready && i_penable)
    else $error("error outside access");
  rdata_hold_a: assert property (!o_pready |-> $stable(o_prdata))
    else $error("read data moved while idle");
  skip_cause_a: assert property (o_skip_taken |-> $past(i_skip_control_field) == 5'h1a)
    else $error("skip without its field value");
  port_flag_a: assert property (i_port_fast_interrupt [*4] |=> o_processor_interrupt_flag)
    else $error("fast request did not flag");
  halt_flag_a: assert property (i_console_halt [*5] |=> o_processor_interrupt_flag)
    else $error("halt did not flag");
endmodule // iid_monitor

// ==== bench/iid_req_model.sv ====
// Far-side request sources: console, backplane devices, port device.
// Each holds its level until the bench withdraws it.
`timescale 1ns/1ns
module iid_req_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Wanted and driven requests, package pin order
  input wire logic [iid_pkg::IID_NUM_PINS-1:0] i_want,
  output logic [iid_pkg::IID_NUM_PINS-1:0] o_req
);
  import iid_pkg::*;
  // Levels only, never pulses: the block sees a held request
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_req <= '0;
    else
      o_req <= i_want;
  end
endmodule // iid_req_model

// ==== bench/interrupt_detect_identify_tb.sv ====
// Self-checking bench for the interrupt detect block.
// Drives APB and the request sources; the checker is bound below.
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module interrupt_detect_identify_tb;
  import iid_pkg::*;
  logic i_clk_sys, i_rst_b, i_psel, i_penable, i_pwrite;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic o_pready, o_pslverr, o_skip_taken, o_processor_interrupt_flag, o_irq;
  logic [4:0] i_skip_control_field;
  logic [8:0] want;
  logic [32:0] q;
  wire logic [8:0] req;
  wire logic i_power_fail, i_timer_expiry, i_bus_request_level_seven, i_bus_request_level_six;
  wire logic i_bus_request_level_five, i_console_attention, i_bus_request_level_four;
  wire logic i_console_halt, i_port_fast_interrupt;
  int err_total = 0;
  int tests_run = 0;
  logic [4:0] lv [7] = '{IID_LVL_POWER_FAIL, IID_LVL_TIMER, IID_LVL_BR7, IID_LVL_BR6,
    IID_LVL_BR5, IID_LVL_BR4_ATTN, IID_LVL_BR4_ATTN};
  assign {i_port_fast_interrupt, i_console_halt, i_bus_request_level_four, i_console_attention,
    i_bus_request_level_five, i_bus_request_level_six, i_bus_request_level_seven,
    i_timer_expiry, i_power_fail} = req;
  iid_top dut (.*);
  iid_req_model far_side (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_want(want), .o_req(req));
  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  task automatic close_out;
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Ready and data are taken at the rising edge that samples ready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end
    while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1)
    begin
      err_total++;
      close_out();
    end
    q = {o_pslverr, o_prdata};
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // Model, sync, identify and flag take five edges
  task automatic settle;
    repeat (8) @(posedge i_clk_sys);
  endtask
  task automatic t_reset;
    `CHK(o_processor_interrupt_flag, 1'b0)
    apb(1'b0, IID_OFS_IDENT, 32'h0);
    `CHK(q[5:0], 6'h0f)
    apb(1'b0, IID_OFS_CTRL, 32'h0);
    `CHK(q, 33'h0)
    apb(1'b0, 8'h20, 32'h0);
    `CHK(q, 33'h1_0000_0000)
    $display("reset test done");
  endtask
  task automatic t_levels;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, IID_OFS_CTRL, {27'h0, lv[i] - 5'h01});
      want <= 9'h001 << i;
      settle();
      apb(1'b0, IID_OFS_IDENT, 32'h0);
      `CHK(q[4:0], {2'b11, i[2:0]})
      apb(1'b0, IID_OFS_DISPATCH, 32'h0);
      `CHK(q[4:0], lv[i])
      apb(1'b1, IID_OFS_CTRL, {27'h0, lv[i]});
      settle();
      apb(1'b0, IID_OFS_IDENT, 32'h0);
      `CHK(q[4:0], 5'h0f)
      want <= 9'h000;
      settle();
    end
    $display("level test done");
  endtask
  task automatic t_order;
    apb(1'b1, IID_OFS_CTRL, 32'h0);
    want <= 9'h07f;
    for (int i = 0; i < 7; i++)
    begin
      settle();
      apb(1'b0, IID_OFS_IDENT, 32'h0);
      `CHK(q[4:0], {2'b11, i[2:0]})
      want[i] <= 1'b0;
    end
    settle();
    $display("order test done");
  endtask
  task automatic t_block;
    apb(1'b1, IID_OFS_CTRL, 32'h1f);
    want <= 9'h07f;
    settle();
    apb(1'b0, IID_OFS_IDENT, 32'h0);
    `CHK(q[4:0], 5'h0f)
    apb(1'b1, IID_OFS_CTRL, 32'h3f);
    settle();
    apb(1'b0, IID_OFS_IDENT, 32'h0);
    `CHK(q[4:0], 5'h1f)
    want <= 9'h0ff;
    settle();
    apb(1'b0, IID_OFS_IDENT, 32'h0);
    `CHK(q[4:0], 5'h17)
    apb(1'b1, IID_OFS_CTRL, 32'h20);
    want <= 9'h004;
    settle();
    apb(1'b0, IID_OFS_IDENT, 32'h0);
    `CHK(q[4:0], 5'h1a)
    apb(1'b1, IID_OFS_CTRL, 32'h1f);
    want <= 9'h000;
    settle();
    $display("block test done");
  endtask
  task automatic t_port;
    apb(1'b1, IID_OFS_INT_STATUS, 32'h7);
    apb(1'b1, IID_OFS_INT_MASK, 32'h7);
    want <= 9'h100;
    i_skip_control_field <= IID_SKIP_PORT_FAST;
    settle();
    `CHK({o_skip_taken, o_irq}, 2'b11)
    apb(1'b0, IID_OFS_IDENT, 32'h0);
    `CHK(q[5:0], 6'h3f)
    apb(1'b0, IID_OFS_INT_STATUS, 32'h0);
    `CHK(q[2:0], 3'h3)
    apb(1'b1, IID_OFS_INT_MASK, 32'h0);
    // Output register follows the new mask one edge after the write
    repeat (2) @(posedge i_clk_sys);
    `CHK(o_irq, 1'b0)
    want <= 9'h000;
    i_skip_control_field <= 5'h00;
    settle();
    apb(1'b1, IID_OFS_INT_STATUS, 32'h7);
    apb(1'b0, IID_OFS_INT_STATUS, 32'h0);
    `CHK({q[2:0], o_processor_interrupt_flag, o_skip_taken}, 5'h0)
    $display("port test done");
  endtask
  task automatic t_vector;
    apb(1'b1, IID_OFS_VT_BASE, 32'h0000_1000);
    apb(1'b1, IID_OFS_VT_VECTOR, 32'h205);
    apb(1'b0, IID_OFS_VT_VECTOR, 32'h0);
    `CHK(q, 33'h0_0000_1205)
    apb(1'b1, IID_OFS_VT_VECTOR, 32'h005);
    apb(1'b0, IID_OFS_VT_VECTOR, 32'h0);
    `CHK(q, 33'h0_0000_1005)
    apb(1'b1, IID_OFS_TABLE_ENTRY, 32'h8000_1233);
    apb(1'b0, IID_OFS_TABLE_ENTRY, 32'h0);
    `CHK(q, 33'h0_8000_1233)
    $display("vector test done");
  endtask
  initial
  begin
    i_rst_b = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_skip_control_field = 5'h00;
    want = 9'h000;
    repeat (5) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    t_reset();
    t_levels();
    t_order();
    t_block();
    t_port();
    t_vector();
    close_out();
  end
endmodule // interrupt_detect_identify_tb
bind iid_top iid_monitor mon (
  .i_clk_sys(i_clk_sys),
  .i_rst_b(i_rst_b),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .o_prdata(o_prdata),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .i_console_halt(i_console_halt),
  .i_port_fast_interrupt(i_port_fast_interrupt),
  .i_skip_control_field(i_skip_control_field),
  .o_skip_taken(o_skip_taken),
  .o_processor_interrupt_flag(o_processor_interrupt_flag)
);

// ==== hw/iid_pkg.sv ====
// Constants for the interrupt detect and identify block.
// Assumes a single 10 MHz system clock and a 32-bit APB register bus.
package iid_pkg;
  // Register byte offsets
  localparam logic [7:0] IID_OFS_CTRL = 8'h00;
  localparam logic [7:0] IID_OFS_IDENT = 8'h04;
  localparam logic [7:0] IID_OFS_VT_BASE = 8'h08;
  localparam logic [7:0] IID_OFS_VT_VECTOR = 8'h0c;
  localparam logic [7:0] IID_OFS_DISPATCH = 8'h10;
  localparam logic [7:0] IID_OFS_INT_STATUS = 8'h14;
  localparam logic [7:0] IID_OFS_INT_MASK = 8'h18;
  localparam logic [7:0] IID_OFS_TABLE_ENTRY = 8'h1c;
  // Control fields
  localparam int IID_CTRL_LEVEL_LSB = 0;
  localparam int IID_CTRL_TRACE_EN_BIT = 5;
  localparam int IID_CTRL_TRACE_PEND_BIT = 6;
  // Vector register: bit 9 marks a bus device vector
  localparam int IID_VEC_BUS_BIT = 9;
  localparam logic [9:0] IID_BUS_PAGE_OFFSET = 10'h200;
  // Reset values
  localparam logic [4:0] IID_LEVEL_RESET = 5'h00;
  localparam logic [3:0] IID_ID_RESET = 4'h0;
  localparam logic [31:0] IID_WORD_RESET = 32'h0000_0000;
  // Skip control value that selects the port fast interrupt
  localparam logic [4:0] IID_SKIP_PORT_FAST = 5'h1a;
  // Pin vector positions, highest service order first
  localparam int IID_PIN_POWER_FAIL = 0;
  localparam int IID_PIN_TIMER = 1;
  localparam int IID_PIN_BR7 = 2;
  localparam int IID_PIN_BR6 = 3;
  localparam int IID_PIN_BR5 = 4;
  localparam int IID_PIN_ATTENTION = 5;
  localparam int IID_PIN_BR4 = 6;
  localparam int IID_PIN_HALT = 7;
  localparam int IID_PIN_PORT_FAST = 8;
  localparam int IID_NUM_PINS = 9;
  localparam int IID_NUM_LEVELED = 7;
  // Interrupt status bits
  localparam int IID_ST_FLAG = 0;
  localparam int IID_ST_PORT = 1;
  localparam int IID_ST_HALT = 2;
  localparam int IID_NUM_EVENTS = 3;
  // Fixed request levels
  localparam logic [4:0] IID_LVL_POWER_FAIL = 5'h1e;
  localparam logic [4:0] IID_LVL_TIMER = 5'h18;
  localparam logic [4:0] IID_LVL_BR7 = 5'h17;
  localparam logic [4:0] IID_LVL_BR6 = 5'h16;
  localparam logic [4:0] IID_LVL_BR5 = 5'h15;
  localparam logic [4:0] IID_LVL_BR4_ATTN = 5'h14;

  // Level of the request named by a stored encoder code
  function automatic logic [4:0] iid_level_of(input logic [2:0] code);
    case (code)
      3'h7: iid_level_of = IID_LVL_POWER_FAIL;
      3'h6: iid_level_of = IID_LVL_TIMER;
      3'h5: iid_level_of = IID_LVL_BR7;
      3'h4: iid_level_of = IID_LVL_BR6;
      3'h3: iid_level_of = IID_LVL_BR5;
      3'h2: iid_level_of = IID_LVL_BR4_ATTN;
      3'h1: iid_level_of = IID_LVL_BR4_ATTN;
      default: iid_level_of = 5'h00;
    endcase
  endfunction
endpackage

// ==== hw/iid_top.sv ====
// Interrupt detection and identification with an APB register slave.
// Assumes request pins are asynchronous levels held until serviced,
// and the skip control field comes from logic on the same clock.
// Overview of operation
// [RULE1] Leveled request only above current level
// [RULE2] Halt and port fast interrupt bypass levels
// [RULE3] Trace only when nothing leveled above
// [RULE4] Fixed request levels per source
// [RULE5] Fixed identifier code per source
// [RULE6] Fixed combined service order
// [RULE7] Port uses bus line plus fast interrupt
// [RULE8] Port fast interrupt is skip condition
// [RULE9] Corrected read error never sets flag
// [RULE10] Level 1F blocks all leveled requests
// [RULE11] Identifier readable in status register
// [RULE12] Table address is base plus offset
// [RULE13] Bus vectors land in second page
// [RULE14] Entry low bits are handling control
// [RULE15] Dispatch level is serviced level, trace keeps
// [RULE16] Direct flag set, else identifier first
// [RULE17] Read identifier is flip-flop complement
// [RULE18] Encoder gives 3-bit code, 0 none
// [RULE19] Reset clears identifier and flag
`timescale 1ns/1ns
module iid_top #(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Request pins
  input wire logic i_power_fail,
  input wire logic i_timer_expiry,
  input wire logic i_console_attention,
  input wire logic i_console_halt,
  input wire logic i_bus_request_level_seven,
  input wire logic i_bus_request_level_six,
  input wire logic i_bus_request_level_five,
  input wire logic i_bus_request_level_four,
  input wire logic i_port_fast_interrupt,
  // Microsequencer
  input wire logic [4:0] i_skip_control_field,
  output logic o_skip_taken,
  // Interrupt outputs
  output logic o_processor_interrupt_flag,
  output logic o_irq
);
  import iid_pkg::*;

  if (SYNC_STAGES < 2)
  begin : g_bad_sync
    $error("iid_top: SYNC_STAGES must be at least 2");
  end

  // SYNC_STAGES-stage synchronisers (two by default), one per pin
  logic [IID_NUM_PINS-1:0] pin_raw;
  logic [IID_NUM_PINS-1:0] pin_sync;
  assign pin_raw = {i_port_fast_interrupt, i_console_halt, i_bus_request_level_four,
                    i_console_attention, i_bus_request_level_five,
                    i_bus_request_level_six, i_bus_request_level_seven,
                    i_timer_expiry, i_power_fail};

  genvar gi;
  generate
    for (gi = 0; gi < IID_NUM_PINS; gi++)
    begin : g_sync
      logic [SYNC_STAGES-1:0] stage_reg;
      always_ff @(posedge i_clk_sys or negedge i_rst_b)
      begin
        if (!i_rst_b)
          stage_reg <= '0;
        else
          stage_reg <= {stage_reg[SYNC_STAGES-2:0], pin_raw[gi]};
      end
      assign pin_sync[gi] = stage_reg[SYNC_STAGES-1];
    end
  endgenerate

  // Software state
  logic [4:0] priority_level_reg;
  logic trace_enable_reg;
  logic trace_pending_bit_reg;
  logic [31:0] vt_base_reg;
  logic [9:0] vt_vector_reg;
  logic [31:0] table_entry_reg;
  logic [IID_NUM_EVENTS-1:0] int_status_reg;
  logic [IID_NUM_EVENTS-1:0] int_mask_reg;
  // Hardware state
  logic [3:0] id_reg;
  logic flag_reg;
  logic port_seen_reg;
  logic halt_seen_reg;
  logic skip_reg;
  logic irq_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // Priority encoder over leveled requests; index 0 is highest
  logic [2:0] enc_code;
  always_comb
  begin
    enc_code = 3'h0;
    for (int k = IID_NUM_LEVELED - 1; k >= 0; k--)
    begin
      if (pin_sync[k])
        enc_code = 3'(IID_NUM_LEVELED - k); // see [RULE18] see [RULE6]
    end
  end

  // Level comparison; no source reaches 1F so that level blocks all
  wire [4:0] enc_level = iid_level_of(enc_code); // see [RULE4]
  wire leveled_above = (enc_code != 3'h0) && (enc_level > priority_level_reg); // see [RULE1] see [RULE10]
  wire halt_req = pin_sync[IID_PIN_HALT]; // see [RULE2]
  wire port_req = pin_sync[IID_PIN_PORT_FAST]; // see [RULE2] see [RULE7]
  wire trace_req = (trace_enable_reg | trace_pending_bit_reg) & ~leveled_above; // see [RULE3]

  // Stored code is complement of read code: power fail reads 000
  wire [3:0] id_next = {halt_req, leveled_above ? enc_code : 3'h0}; // see [RULE5]
  // Corrected read errors have no input here; microcode raises them
  wire flag_next = port_req | trace_req | (id_reg != 4'h0); // see [RULE16] see [RULE9]
  wire skip_next = (i_skip_control_field == IID_SKIP_PORT_FAST) & port_req; // see [RULE8]

  // Identifier as microcode reads it
  wire [3:0] id_read = ~id_reg; // see [RULE17] see [RULE11]

  // Vector table address
  wire vec_is_bus = vt_vector_reg[IID_VEC_BUS_BIT];
  wire [9:0] vt_offset = vec_is_bus ? ({1'b0, vt_vector_reg[8:0]} + IID_BUS_PAGE_OFFSET)
                                    : vt_vector_reg; // see [RULE13]
  wire [31:0] vt_address = vt_base_reg + {22'h000000, vt_offset}; // see [RULE12]
  // Handler address and control bits split out of the entry
  wire [31:0] entry_read = {table_entry_reg[31:2], table_entry_reg[1:0]}; // see [RULE14]

  // New level on dispatch; halt and trace keep current level
  wire [4:0] dispatch_level = (id_reg[2:0] != 3'h0) ? iid_level_of(id_reg[2:0])
                                                    : priority_level_reg; // see [RULE15]

  // Events: flag rise, port fast rise, halt rise
  wire [IID_NUM_EVENTS-1:0] ev_set;
  assign ev_set[IID_ST_FLAG] = flag_next & ~flag_reg;
  assign ev_set[IID_ST_PORT] = port_req & ~port_seen_reg;
  assign ev_set[IID_ST_HALT] = halt_req & ~halt_seen_reg;

  // APB decode
  wire setup = i_psel & ~i_penable;
  wire wr_en = i_psel & i_penable & pready_reg & i_pwrite;
  wire sel_ctrl = (i_paddr == IID_OFS_CTRL);
  wire sel_ident = (i_paddr == IID_OFS_IDENT);
  wire sel_base = (i_paddr == IID_OFS_VT_BASE);
  wire sel_vec = (i_paddr == IID_OFS_VT_VECTOR);
  wire sel_disp = (i_paddr == IID_OFS_DISPATCH);
  wire sel_stat = (i_paddr == IID_OFS_INT_STATUS);
  wire sel_mask = (i_paddr == IID_OFS_INT_MASK);
  wire sel_entry = (i_paddr == IID_OFS_TABLE_ENTRY);
  wire mapped = sel_ctrl | sel_ident | sel_base | sel_vec | sel_disp | sel_stat
                | sel_mask | sel_entry;

  // Status clear loses to a coincident set
  wire [IID_NUM_EVENTS-1:0] st_clear = (wr_en && sel_stat) ?
                                       i_pwdata[IID_NUM_EVENTS-1:0] : '0;
  wire [IID_NUM_EVENTS-1:0] status_next = (int_status_reg & ~st_clear) | ev_set;

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl)
      rd_mux = {25'h0, trace_pending_bit_reg, trace_enable_reg, priority_level_reg};
    else if (sel_ident)
      rd_mux = {26'h0, port_req, flag_reg, id_read};
    else if (sel_base)
      rd_mux = vt_base_reg;
    else if (sel_vec)
      rd_mux = vt_address;
    else if (sel_disp)
      rd_mux = {27'h0, dispatch_level};
    else if (sel_stat)
      rd_mux = {29'h0, int_status_reg};
    else if (sel_mask)
      rd_mux = {29'h0, int_mask_reg};
    else if (sel_entry)
      rd_mux = entry_read;
  end

  // Detection state; reset reports nothing until a fresh request
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      id_reg <= IID_ID_RESET; // see [RULE19]
      flag_reg <= 1'b0; // see [RULE19]
      port_seen_reg <= 1'b0;
      halt_seen_reg <= 1'b0;
      skip_reg <= 1'b0;
      int_status_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      id_reg <= id_next;
      flag_reg <= flag_next;
      port_seen_reg <= port_req;
      halt_seen_reg <= halt_req;
      skip_reg <= skip_next;
      int_status_reg <= status_next;
      irq_reg <= |(status_next & int_mask_reg);
    end
  end

  // Software registers
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      priority_level_reg <= IID_LEVEL_RESET;
      trace_enable_reg <= 1'b0;
      trace_pending_bit_reg <= 1'b0;
      vt_base_reg <= IID_WORD_RESET;
      vt_vector_reg <= 10'h000;
      table_entry_reg <= IID_WORD_RESET;
      int_mask_reg <= '0;
    end
    else if (wr_en)
    begin
      if (sel_ctrl)
      begin
        priority_level_reg <= i_pwdata[IID_CTRL_LEVEL_LSB +: 5];
        trace_enable_reg <= i_pwdata[IID_CTRL_TRACE_EN_BIT];
        trace_pending_bit_reg <= i_pwdata[IID_CTRL_TRACE_PEND_BIT];
      end
      if (sel_base)
        vt_base_reg <= i_pwdata;
      if (sel_vec)
        vt_vector_reg <= i_pwdata[9:0];
      if (sel_entry)
        table_entry_reg <= i_pwdata;
      if (sel_mask)
        int_mask_reg <= i_pwdata[IID_NUM_EVENTS-1:0];
    end
  end

  // Zero-wait APB answer, captured in the setup cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      prdata_reg <= IID_WORD_RESET;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~mapped;
      if (setup)
        prdata_reg <= i_pwrite ? IID_WORD_RESET : rd_mux;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_skip_taken = skip_reg;
  assign o_processor_interrupt_flag = flag_reg;
  assign o_irq = irq_reg;
endmodule // iid_top
